// ---- include/gwt_pkg.sv ----
package gwt_pkg;

   // ------------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------------
   localparam logic [31:0] GT_LOAD_ADDR  = 32'hFFFF0320;
   localparam logic [31:0] GT_COUNT_ADDR = 32'hFFFF0324;
   localparam logic [31:0] GT_CTL_ADDR   = 32'hFFFF0328;
   localparam logic [31:0] GT_CLEAR_ADDR = 32'hFFFF032C;
   localparam logic [31:0] GT_CAP_ADDR   = 32'hFFFF0330;
   localparam logic [31:0] WT_LOAD_ADDR  = 32'hFFFF0340;
   localparam logic [31:0] WT_COUNT_ADDR = 32'hFFFF0344;
   localparam logic [31:0] WT_CTL_ADDR   = 32'hFFFF0348;
   localparam logic [31:0] WT_CLEAR_ADDR = 32'hFFFF034C;
   localparam logic [31:0] WT_CAP_ADDR   = 32'hFFFF0350;

   // ------------------------------------------------------------------
   // Control fields and reset values
   // ------------------------------------------------------------------
   localparam int          POST_LSB      = 24;
   localparam int          POST_WEN      = 23;
   localparam int          CMP_FLAG      = 19;
   localparam int          IRQ_SEL       = 18;
   localparam int          CAP_EN        = 17;
   localparam int          EVSEL_LSB     = 12;
   localparam int          GT_CLK_LSB    = 9;
   localparam int          WT_CLK_LSB    = 9;
   localparam int          COUNT_UP      = 8;
   localparam int          TMR_EN        = 7;
   localparam int          PERIODIC      = 6;
   localparam int          FMT_LSB       = 4;
   localparam int          PRE_LSB       = 0;
   localparam logic [31:0] GT_CTL_WMASK  = 32'h0007FFFF;
   localparam logic [31:0] POST_MASK     = 32'hFF000000;
   localparam logic [31:0] WT_CTL_WMASK  = 32'h000007FF;
   localparam logic [31:0] CTL_RESET     = 32'h00000000;
   localparam logic [31:0] LOAD_RESET    = 32'h00000000;
   localparam logic [31:0] COUNT_RESET   = 32'h00000000;

   // ------------------------------------------------------------------
   // Count format limits
   // ------------------------------------------------------------------
   localparam logic [1:0]  FMT_HMS_LONG  = 2'h3;
   localparam logic [7:0]  HUND_MAX      = 8'h63;
   localparam logic [7:0]  SEC_MAX       = 8'h3B;
   localparam logic [7:0]  HOUR_SHORT    = 8'h17;
   localparam logic [7:0]  HOUR_LONG     = 8'hFF;
   localparam logic [4:0]  EVENT_MAX     = 5'h11;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } gwt_ahb_req_t;

   typedef struct packed {
      logic [31:0] ctl;
      logic [31:0] load;
      logic [31:0] cnt;
      logic [31:0] cap;
      logic [14:0] pre;
      logic        irq;
   } gwt_timer_t;

   typedef struct packed {
      logic [3:0][2:0]     sync;
      gwt_timer_t [1:0]    tmr;
      logic [7:0]          post;
      logic [17:0]         ev_prev;
      logic                wcap_prev;
      logic                wr_pend;
      logic [31:0]         waddr;
      logic [31:0]         hrdata;
   } gwt_state_t;

endpackage : gwt_pkg

// ---- logic/gwt_timers.sv ----
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
// Operation
// R1: Control top byte holds postscaler; written only when bit 23 of the write is set.
// R2: Control bit 19 is postscaler compare flag, bit 18 selects interrupt source.
// R3: Capture enable bit 17 enables or disables event capture.
// R4: Five-bit event select picks capture source 0 to 17.
// R5: General clock select: 000 oscillator, 001 core, 010 undivided, 011 pin.
// R6: Direction bit set counts up, clear counts down.
// R7: Timer runs only while its enable bit is set.
// R8: Mode bit set is periodic, clear is free-running.
// R9: Format 00 binary, 10 clock time to 23 hours, 11 to 255 hours.
// R10: Prescaler code n divides source by two to the n, both timers.
// R11: Wake timer is a 32-bit up or down counter behind a prescaler.
// R12: Wake timer source: core (default), oscillator, crystal or undivided clock.
// R13: Wake timer keeps counting while the core clock is stopped.
// R14: Wake capture works only while wake interrupt enable bit 4 is set.
// R15: Wake count is plain binary or hours, minutes, seconds, hundredths.
// R16: Wake timer reloads from load register on overflow and on clear write. Code reloads on overflow only when the mode bit selects periodic.
// R17: Any write to clear register drops pending interrupt and reloads counter.
// R18: Count register is read-only current value; load register holds reload value.
// R19: Hundredths wrap after 99, seconds and minutes after 59, hours at limit.
// R20: General timer counts timeouts against postscaler and flags a match.
module gwt_timers #(
   parameter int NUM_EVENTS = 18
) (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // AHB-Lite slave
   input  wire gwt_pkg::gwt_ahb_req_t ahb_req_i,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   output logic [31:0]                hrdata_o,
   // Clock source pins
   input  wire logic                  osc32_i,
   input  wire logic                  xtal32_i,
   input  wire logic                  external_count_pin_i,
   input  wire logic                  undivided_clock_i,
   // System side
   input  wire logic                  core_halt_i,
   input  wire logic [NUM_EVENTS-1:0] events_i,
   input  wire logic                  wake_irq_enable_i,
   input  wire logic                  wake_capture_i,
   output logic                       general_irq_o,
   output logic                       wake_irq_o
);

   gwt_pkg::gwt_state_t s;
   gwt_pkg::gwt_state_t next_s;

   // ------------------------------------------------------------------
   // Count step for binary and clock-time formats
   // ------------------------------------------------------------------
   function automatic logic [32:0] gwt_step(input logic [31:0] v,
                                            input logic        up,
                                            input logic [1:0]  fmt);
      logic [31:0] r;
      logic        w;
      logic [7:0]  hl;
      r  = v;
      w  = 1'b0;
      hl = (fmt == gwt_pkg::FMT_HMS_LONG) ? gwt_pkg::HOUR_LONG : gwt_pkg::HOUR_SHORT;
      if (!fmt[1]) begin
         r = up ? v + 32'h1 : v - 32'h1;
         w = up ? (v == 32'hFFFFFFFF) : (v == 32'h0);
      end else if (up) begin
         r[7:0] = v[7:0] + 8'h1; // [R19]
         if (v[7:0] >= gwt_pkg::HUND_MAX) begin
            r[7:0]  = 8'h0;
            r[15:8] = v[15:8] + 8'h1;
            if (v[15:8] >= gwt_pkg::SEC_MAX) begin
               r[15:8]  = 8'h0;
               r[23:16] = v[23:16] + 8'h1;
               if (v[23:16] >= gwt_pkg::SEC_MAX) begin
                  r[23:16] = 8'h0;
                  r[31:24] = v[31:24] + 8'h1;
                  if (v[31:24] >= hl) begin
                     r[31:24] = 8'h0;
                     w        = 1'b1;
                  end
               end
            end
         end
      end else begin
         r[7:0] = v[7:0] - 8'h1; // [R19]
         if (v[7:0] == 8'h0) begin
            r[7:0]  = gwt_pkg::HUND_MAX;
            r[15:8] = v[15:8] - 8'h1;
            if (v[15:8] == 8'h0) begin
               r[15:8]  = gwt_pkg::SEC_MAX;
               r[23:16] = v[23:16] - 8'h1;
               if (v[23:16] == 8'h0) begin
                  r[23:16] = gwt_pkg::SEC_MAX;
                  r[31:24] = v[31:24] - 8'h1;
                  if (v[31:24] == 8'h0) begin
                     r[31:24] = hl;
                     w        = 1'b1;
                  end
               end
            end
         end
      end
      return {w, r};
   endfunction : gwt_step

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [3:0]  pins;
      logic [3:0]  src_edge;
      logic        take;
      logic        wr_on;
      logic [31:0] wd;
      logic        clr;
      logic        src;
      logic        tick;
      logic        tmo;
      logic        cmp;
      logic [15:0] m16;
      logic [32:0] st;
      logic [31:0] c;
      logic [17:0] ev_rise;
      logic [4:0]  sel;
      next_s   = s;
      pins     = {undivided_clock_i, external_count_pin_i, xtal32_i, osc32_i};
      src_edge = 4'h0;
      take     = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
      wr_on    = s.wr_pend;
      wd       = ahb_req_i.hwdata;
      clr      = 1'b0;
      src      = 1'b0;
      tick     = 1'b0;
      tmo      = 1'b0;
      cmp      = 1'b0;
      m16      = 16'h0;
      st       = 33'h0;
      c        = 32'h0;
      ev_rise  = 18'h0;
      sel      = 5'h0;

      // Pin sources pass two flops; the third flop only serves edge detection.
      for (int i = 0; i < 4; i++) begin
         next_s.sync[i] = {s.sync[i][1:0], pins[i]};
         src_edge[i]    = s.sync[i][1] & ~s.sync[i][2];
      end

      // Address phase: capture write intent, or fetch read data for the data phase.
      next_s.wr_pend = take & ahb_req_i.hwrite;
      next_s.waddr   = ahb_req_i.haddr;
      next_s.hrdata  = 32'h0;
      if (take && !ahb_req_i.hwrite) begin
         unique case (ahb_req_i.haddr)
            gwt_pkg::GT_LOAD_ADDR:  next_s.hrdata = s.tmr[0].load;
            gwt_pkg::GT_COUNT_ADDR: next_s.hrdata = s.tmr[0].cnt;
            gwt_pkg::GT_CTL_ADDR:   next_s.hrdata = s.tmr[0].ctl;
            gwt_pkg::GT_CAP_ADDR:   next_s.hrdata = s.tmr[0].cap;
            gwt_pkg::WT_LOAD_ADDR:  next_s.hrdata = s.tmr[1].load; // [R18]
            gwt_pkg::WT_COUNT_ADDR: next_s.hrdata = s.tmr[1].cnt;  // [R18]
            gwt_pkg::WT_CTL_ADDR:   next_s.hrdata = s.tmr[1].ctl;
            gwt_pkg::WT_CAP_ADDR:   next_s.hrdata = s.tmr[1].cap;
            default:                next_s.hrdata = 32'h0;
         endcase
      end

      // Data phase writes. Count registers ignore writes.
      if (wr_on) begin
         unique case (s.waddr)
            gwt_pkg::GT_LOAD_ADDR: next_s.tmr[0].load = wd;
            gwt_pkg::WT_LOAD_ADDR: next_s.tmr[1].load = wd; // [R18]
            gwt_pkg::GT_CTL_ADDR: begin
               next_s.tmr[0].ctl = (s.tmr[0].ctl & ~gwt_pkg::GT_CTL_WMASK)
                                 | (wd & gwt_pkg::GT_CTL_WMASK);
               if (wd[gwt_pkg::POST_WEN]) begin // [R1]
                  next_s.tmr[0].ctl = (next_s.tmr[0].ctl & ~gwt_pkg::POST_MASK)
                                    | (wd & gwt_pkg::POST_MASK);
               end
            end
            gwt_pkg::WT_CTL_ADDR: begin
               next_s.tmr[1].ctl = wd & gwt_pkg::WT_CTL_WMASK;
            end
            default: begin
            end
         endcase
      end

      // Per-timer prescaler, counter, reload and timeout.
      for (int t = 0; t < 2; t++) begin
         c = s.tmr[t].ctl;
         if (t == 0) begin
            unique case (c[gwt_pkg::GT_CLK_LSB +: 3]) // [R5]
               3'h0:    src = src_edge[0];
               3'h1:    src = ~core_halt_i;
               3'h2:    src = src_edge[3];
               3'h3:    src = src_edge[2];
               default: src = 1'b0;
            endcase
         end else begin
            // The wake timer runs on the always-on block clock, so a halted
            // core does not stop it.
            unique case (c[gwt_pkg::WT_CLK_LSB +: 2]) // [R12] [R13]
               2'h0: src = 1'b1;
               2'h1: src = src_edge[0];
               2'h2: src = src_edge[1];
               2'h3: src = src_edge[3];
            endcase
         end
         m16  = (16'h1 << c[gwt_pkg::PRE_LSB +: 4]) - 16'h1; // [R10]
         tick = 1'b0;
         tmo  = 1'b0;
         if (c[gwt_pkg::TMR_EN] && src) begin // [R7]
            next_s.tmr[t].pre = s.tmr[t].pre + 15'h1;
            if ((s.tmr[t].pre & m16[14:0]) == m16[14:0]) begin
               next_s.tmr[t].pre = 15'h0;
               tick              = 1'b1;
            end
         end
         st = gwt_step(s.tmr[t].cnt, c[gwt_pkg::COUNT_UP], c[gwt_pkg::FMT_LSB +: 2]); // [R6] [R9] [R11] [R15]
         if (tick) begin
            tmo               = st[32];
            next_s.tmr[t].cnt = st[31:0];
            if (st[32] && c[gwt_pkg::PERIODIC]) begin // [R8] [R16]
               next_s.tmr[t].cnt = s.tmr[t].load;
            end
         end
         clr = wr_on && (s.waddr == (t == 0 ? gwt_pkg::GT_CLEAR_ADDR : gwt_pkg::WT_CLEAR_ADDR));
         if (clr) begin // [R16] [R17]
            next_s.tmr[t].cnt = s.tmr[t].load;
            next_s.tmr[t].pre = 15'h0;
            next_s.tmr[t].irq = 1'b0;
            if (t == 0) begin
               next_s.tmr[0].ctl[gwt_pkg::CMP_FLAG] = 1'b0;
            end
         end
         // Sets are applied after the clear so an event in the clear cycle survives.
         if (t == 0) begin
            cmp = 1'b0;
            if (tmo) begin // [R20]
               next_s.post = s.post + 8'h1;
               if (s.post == c[gwt_pkg::POST_LSB +: 8]) begin
                  next_s.post = 8'h0;
                  cmp         = 1'b1;
               end
            end
            if (cmp) begin
               next_s.tmr[0].ctl[gwt_pkg::CMP_FLAG] = 1'b1; // [R2]
            end
            if (c[gwt_pkg::IRQ_SEL] ? cmp : tmo) begin // [R2]
               next_s.tmr[0].irq = 1'b1;
            end
         end else if (tmo) begin
            next_s.tmr[1].irq = 1'b1;
         end
      end

      // Event capture on the first assertion of the selected event.
      ev_rise        = events_i & ~s.ev_prev;
      next_s.ev_prev = events_i;
      sel            = s.tmr[0].ctl[gwt_pkg::EVSEL_LSB +: 5];
      if (s.tmr[0].ctl[gwt_pkg::CAP_EN] && sel <= gwt_pkg::EVENT_MAX) begin // [R3] [R4]
         if (ev_rise[sel]) begin
            next_s.tmr[0].cap = s.tmr[0].cnt;
         end
      end
      next_s.wcap_prev = wake_capture_i;
      if (wake_capture_i && !s.wcap_prev && wake_irq_enable_i) begin // [R14]
         next_s.tmr[1].cap = s.tmr[1].cnt;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
         for (int t = 0; t < 2; t++) begin
            s.tmr[t].ctl  <= gwt_pkg::CTL_RESET;
            s.tmr[t].load <= gwt_pkg::LOAD_RESET;
            s.tmr[t].cnt  <= gwt_pkg::COUNT_RESET;
         end
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // The slave never inserts wait states and never signals an error.
   assign hreadyout_o   = 1'b1;
   assign hresp_o       = 1'b0;
   assign hrdata_o      = s.hrdata;
   assign general_irq_o = s.tmr[0].irq;
   assign wake_irq_o    = s.tmr[1].irq;

endmodule : gwt_timers

// ---- tb/gwt_timers_props.sv ----
`timescale 1ns/1ps
module gwt_timers_props #(
   parameter int NUM_EVENTS = 18
) (
   // Clock, reset and bus
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire gwt_pkg::gwt_ahb_req_t ahb_req_i,
   input  wire logic                  hreadyout_o,
   input  wire logic                  hresp_o,
   input  wire logic [31:0]           hrdata_o,
   // Interrupts
   input  wire logic                  general_irq_o,
   input  wire logic                  wake_irq_o
);
   logic        ap_v, ap_w;
   logic [31:0] ap_a, wld, wctl;
   logic [18:0] gctl;
   logic [7:0]  gpost;
   wire  logic  wrp   = ap_v & ap_w;
   wire  logic  rd_wl = ap_v & ~ap_w & (ap_a == gwt_pkg::WT_LOAD_ADDR);
   wire  logic  rd_wc = ap_v & ~ap_w & (ap_a == gwt_pkg::WT_CTL_ADDR);
   wire  logic  rd_gc = ap_v & ~ap_w & (ap_a == gwt_pkg::GT_CTL_ADDR);
   wire  logic  rd_cl = ap_v & ~ap_w & (ap_a == gwt_pkg::WT_CLEAR_ADDR);
   // ---------------------------------------------------------------
   // Shadow registers.
   // ---------------------------------------------------------------
   // Shadows follow writes at the end of the data phase, as the design does.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {ap_v, ap_w, ap_a, wld, wctl, gctl, gpost} <= '0;
      end else begin
         ap_v <= ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
         ap_w <= ahb_req_i.hwrite;
         ap_a <= ahb_req_i.haddr;
         if (wrp && ap_a == gwt_pkg::WT_LOAD_ADDR) wld <= ahb_req_i.hwdata;
         if (wrp && ap_a == gwt_pkg::WT_CTL_ADDR) wctl <= ahb_req_i.hwdata & gwt_pkg::WT_CTL_WMASK;
         if (wrp && ap_a == gwt_pkg::GT_CTL_ADDR) gctl <= ahb_req_i.hwdata[18:0];
         if (wrp && ap_a == gwt_pkg::GT_CTL_ADDR && ahb_req_i.hwdata[23]) begin
            gpost <= ahb_req_i.hwdata[31:24];
         end
      end
   end
   // ---------------------------------------------------------------
   // Properties.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer is not ready and OKAY");
   AST_RD_IDLE: assert property (!(ap_v && !ap_w) |-> hrdata_o == 32'h0)
      else $error("read data not zero outside a read data phase");
   AST_WLOAD_READ: assert property (rd_wl |-> hrdata_o == wld)
      else $error("wake load readback differs from last write");
   AST_WCTL_READ: assert property (rd_wc |-> hrdata_o == wctl)
      else $error("wake control readback differs from last write");
   AST_GCTL_FIELDS: assert property (rd_gc |-> hrdata_o[18:0] == gctl && hrdata_o[23:20] == 4'h0)
      else $error("general control fields differ from last write");
   AST_GCTL_POST: assert property (rd_gc |-> hrdata_o[31:24] == gpost)
      else $error("postscaler field written without its enable");
   AST_CLEAR_WO: assert property (rd_cl |-> hrdata_o == 32'h0)
      else $error("clear register returned data");
   AST_CLEAR_IRQ: assert property (wrp && ap_a == gwt_pkg::WT_CLEAR_ADDR && !wctl[7]
      && !$past(wctl[7]) |=> !wake_irq_o) else $error("clear write left wake irq set");
   AST_WAKE_HOLD: assert property (!wake_irq_o && !wctl[7] && !$past(wctl[7]) |=> !wake_irq_o)
      else $error("disabled wake timer raised its irq");
   AST_GEN_HOLD: assert property (!general_irq_o && !gctl[7] && !$past(gctl[7])
      |=> !general_irq_o) else $error("disabled general timer raised its irq");
   COV_WLOAD: cover property (rd_wl);
   COV_WIRQ: cover property ($rose(wake_irq_o));
   COV_GIRQ: cover property ($rose(general_irq_o));
endmodule : gwt_timers_props

bind gwt_timers gwt_timers_props #(.NUM_EVENTS(NUM_EVENTS)) u_props (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .ahb_req_i(ahb_req_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .general_irq_o(general_irq_o), .wake_irq_o(wake_irq_o));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic                  clk_i = 1'b0;
   logic                  rst_n_i = 1'b0;
   gwt_pkg::gwt_ahb_req_t m = '0;
   gwt_pkg::gwt_ahb_req_t req;
   logic                  rdy, resp, girq, wirq;
   logic [31:0]           rdata;
   logic                  halt = 1'b0;
   logic                  ien = 1'b0;
   logic                  cap = 1'b0;
   logic [17:0]           ev = '0;
   logic [3:0]            pin = '0;
   int                    n_mismatch = 0;
   int                    checks = 0;
   always #25 clk_i = ~clk_i;
   always_comb begin
      req = m;
      req.hready = rdy;
   end
   // Each source pin toggles at its own rate, so a wrong source choice misses its window.
   always @(posedge clk_i) pin <= pin + 4'h1;
   gwt_timers dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ahb_req_i(req), .hreadyout_o(rdy),
      .hresp_o(resp), .hrdata_o(rdata), .osc32_i(pin[0]), .xtal32_i(pin[1]),
      .external_count_pin_i(pin[2]), .undivided_clock_i(pin[3]), .core_halt_i(halt),
      .events_i(ev), .wake_irq_enable_i(ien), .wake_capture_i(cap), .general_irq_o(girq),
      .wake_irq_o(wirq));
   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Entered just after a rising edge; each phase stands until hready is sampled high.
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      m.hsel <= 1'b1;
      m.htrans <= 2'h2;
      m.haddr <= a;
      m.hwrite <= w;
      m.hsize <= 3'h2;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (rdy !== 1'b1 && n < 50);
         if (rdy !== 1'b1) begin
            n_mismatch++;
            stop_test();
         end
         q = rdata;
         if (p == 0) begin
            m.hsel <= 1'b0;
            m.htrans <= 2'h0;
            m.hwdata <= d;
         end else begin
            chk({31'h0, resp}, 32'h0);
         end
      end
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask : rd
   task automatic irq(input logic g, input logic e, input int lim);
      int   n;
      logic v;
      n = 0;
      do begin
         @(negedge clk_i);
         v = g ? girq : wirq;
         n++;
      end while (v !== e && n < lim);
      chk({31'h0, v}, {31'h0, e});
      if (v !== e && lim > 1) stop_test();
      @(posedge clk_i);
   endtask : irq
   task automatic pulse(input logic g);
      if (g) ev[17] <= 1'b1;
      else cap <= 1'b1;
      @(posedge clk_i);
      ev <= '0;
      cap <= 1'b0;
      @(posedge clk_i);
   endtask : pulse
   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(gwt_pkg::WT_LOAD_ADDR, gwt_pkg::LOAD_RESET);
      rd(gwt_pkg::WT_COUNT_ADDR, gwt_pkg::COUNT_RESET);
      rd(gwt_pkg::WT_CTL_ADDR, gwt_pkg::CTL_RESET);
      rd(gwt_pkg::GT_CTL_ADDR, gwt_pkg::CTL_RESET);
      rd(32'hFFFF0300, 32'h0);
      irq(1'b0, 1'b0, 1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_regs();
      wr(gwt_pkg::WT_LOAD_ADDR, 32'h89ABCDEF);
      rd(gwt_pkg::WT_LOAD_ADDR, 32'h89ABCDEF);
      wr(gwt_pkg::WT_COUNT_ADDR, 32'h00001234);
      rd(gwt_pkg::WT_COUNT_ADDR, 32'h0);
      wr(gwt_pkg::WT_CTL_ADDR, 32'hFFFFFF7F);
      rd(gwt_pkg::WT_CTL_ADDR, 32'hFFFFFF7F & gwt_pkg::WT_CTL_WMASK);
      rd(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::WT_CTL_ADDR, 32'h0);
      wr(gwt_pkg::GT_CTL_ADDR, 32'hFF77FFFF);
      rd(gwt_pkg::GT_CTL_ADDR, 32'h0007FFFF);
      wr(gwt_pkg::GT_CTL_ADDR, 32'hFFFFFFFF);
      rd(gwt_pkg::GT_CTL_ADDR, 32'hFF07FFFF);
      wr(gwt_pkg::WT_LOAD_ADDR, 32'h5);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      rd(gwt_pkg::WT_COUNT_ADDR, 32'h5);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_run();
      halt <= 1'b1;
      wr(gwt_pkg::WT_LOAD_ADDR, 32'h3);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::WT_CTL_ADDR, 32'hC0);
      irq(1'b0, 1'b1, 12);
      wr(gwt_pkg::WT_CTL_ADDR, 32'h0);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      irq(1'b0, 1'b0, 1);
      halt <= 1'b0;
      wr(gwt_pkg::WT_LOAD_ADDR, 32'hFFFFFFFD);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::WT_CTL_ADDR, 32'h1C0);
      irq(1'b0, 1'b1, 12);
      wr(gwt_pkg::WT_CTL_ADDR, 32'h0);
      wr(gwt_pkg::WT_LOAD_ADDR, 32'h0);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::WT_CTL_ADDR, 32'hC4);
      repeat (8) @(posedge clk_i);
      irq(1'b0, 1'b0, 1);
      irq(1'b0, 1'b1, 40);
      wr(gwt_pkg::WT_CTL_ADDR, 32'h0);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      $display("t_run done");
   endtask : t_run
   // Prescaler 256 leaves room to stop the timer after exactly one step.
   task automatic t_fmt();
      logic [31:0] e [4] = '{32'hFFFFFFFF, 32'h0, 32'h173B3B63, 32'hFF3B3B63};
      for (int f = 0; f < 5; f++) begin
         if (f == 1) continue;
         wr(gwt_pkg::WT_LOAD_ADDR, (f == 4) ? 32'h00003B63 : 32'h0);
         wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
         wr(gwt_pkg::WT_CTL_ADDR, (f == 4) ? 32'h1A8 : (32'h88 | (32'(f) << 4)));
         repeat (300) @(posedge clk_i);
         wr(gwt_pkg::WT_CTL_ADDR, 32'h0);
         rd(gwt_pkg::WT_COUNT_ADDR, (f == 4) ? 32'h00010000 : e[f]);
         wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      end
      $display("t_fmt done");
   endtask : t_fmt
   task automatic t_cap();
      wr(gwt_pkg::WT_LOAD_ADDR, 32'h55);
      wr(gwt_pkg::WT_CLEAR_ADDR, 32'h0);
      pulse(1'b0);
      rd(gwt_pkg::WT_CAP_ADDR, 32'h0);
      ien <= 1'b1;
      pulse(1'b0);
      rd(gwt_pkg::WT_CAP_ADDR, 32'h55);
      wr(gwt_pkg::GT_LOAD_ADDR, 32'h77);
      wr(gwt_pkg::GT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::GT_CTL_ADDR, 32'h11000);
      pulse(1'b1);
      rd(gwt_pkg::GT_CAP_ADDR, 32'h0);
      wr(gwt_pkg::GT_CTL_ADDR, 32'h31000);
      pulse(1'b1);
      rd(gwt_pkg::GT_CAP_ADDR, 32'h77);
      $display("t_cap done");
   endtask : t_cap
   // Four ticks of a slow source must not come early, and must come in time.
   task automatic t_src();
      logic        g [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      logic [31:0] v [6] = '{32'h0C0, 32'h4C0, 32'h6C0, 32'h2C0, 32'h4C0, 32'h6C0};
      int          p [6] = '{2, 16, 8, 2, 4, 16};
      logic [31:0] la, ca, ta;
      for (int k = 0; k < 6; k++) begin
         la = g[k] ? gwt_pkg::GT_LOAD_ADDR : gwt_pkg::WT_LOAD_ADDR;
         ca = g[k] ? gwt_pkg::GT_CLEAR_ADDR : gwt_pkg::WT_CLEAR_ADDR;
         ta = g[k] ? gwt_pkg::GT_CTL_ADDR : gwt_pkg::WT_CTL_ADDR;
         wr(la, 32'h3);
         wr(ca, 32'h0);
         wr(ta, v[k]);
         repeat (2 * p[k]) @(posedge clk_i);
         irq(g[k], 1'b0, 1);
         irq(g[k], 1'b1, 3 * p[k] + 8);
         wr(ta, 32'h0);
         wr(ca, 32'h0);
      end
      $display("t_src done");
   endtask : t_src
   task automatic t_post();
      wr(gwt_pkg::GT_LOAD_ADDR, 32'h1);
      wr(gwt_pkg::GT_CLEAR_ADDR, 32'h0);
      wr(gwt_pkg::GT_CTL_ADDR, 32'h028402C0);
      irq(1'b1, 1'b1, 40);
      wr(gwt_pkg::GT_CTL_ADDR, 32'h00040200);
      rd(gwt_pkg::GT_CTL_ADDR, 32'h020C0200);
      wr(gwt_pkg::GT_CLEAR_ADDR, 32'h0);
      rd(gwt_pkg::GT_CTL_ADDR, 32'h02040200);
      irq(1'b1, 1'b0, 1);
      $display("t_post done");
   endtask : t_post
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_regs();
      t_run();
      t_fmt();
      t_cap();
      t_post();
      t_src();
      stop_test();
   end
endmodule : testbench
